// file: src/hardware_loop_stack_unit.sv
// Loop end-address and loop count stacks with their core registers
//
// Contract
// - End-address stack holds six entries of 32 bits.
// - A push while six entries are occupied flags overflow.
// - Both stacks share one occupancy, so one overflow and one empty flag.
// - Every overflow raises a maskable interrupt request.
// - Core reads and writes the top end-address without moving the pointer.
// - Only pushes and pops, explicit or by loop start and termination, move the pointer, not register accesses.
// - Top end-address reads all ones while the stack is empty.
// - Explicit push moves only the pointer; software then writes the entry.
// - Count stack holds six 32-bit entries; full, empty, overflow on full push.
// - A loaded count of zero runs two to the thirty-second iterations.
// - Status bit 25 sets on overflow and stays set until a status register write clears it.
// - Status bit 26 is high while empty, cleared by any push.
// - Top count is core read/write, reads all ones while empty.
// - Writes to current count are ignored while the stack is empty.
// - Current count write never pushes; affects only a running counter loop.
// - Count updates at fetch or execute stage by loop type.
// - Every return acts as re-entry: one decrement per iteration at most.
// - Multiplier status reaches arithmetic abort one machine cycle later.
// - Loop termination pops; initial-count register holds the next count.
// - Loop start pushes initial count as new current count.
// - Initial-count writes are discarded when full; reads then undefined.
// - Loop start pushes end address, condition code and loop type.
`timescale 1ns/1ps
module hardware_loop_stack_unit
  import loop_stack_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer loop control
  input wire logic loop_start,
  input wire logic [ADDR_W-1:0] loop_end_addr,
  input wire logic [COND_W-1:0] loop_cond_code,
  input wire logic [TYPE_W-1:0] loop_kind,
  input wire logic loop_terminate,
  input wire logic push_loop,
  input wire logic pop_loop,
  input wire logic loop_top_fetch,
  input wire logic fetch_stage_terminated_loop,
  input wire logic execute_stage_terminated_loop,
  // Arithmetic abort path
  input wire logic mult_status,
  output logic mult_status_abort,
  // Core data bus
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [1:0] reg_sel,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // Status and events
  input wire logic irq_mask,
  output logic overflow_irq,
  output logic count_expired_condition,
  output logic loop_stacks_empty_flag,
  output logic loop_stacks_overflowed_flag
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_counter(input logic [TYPE_W-1:0] kind);
    is_counter = (kind == LOOP_COUNT_EXEC) || (kind == LOOP_COUNT_FETCH);
  endfunction : is_counter

  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] addr_stack [STACK_DEPTH];
  logic [DATA_W-1:0] count_stack [STACK_DEPTH];
  logic [2:0] depth;
  logic [DATA_W-1:0] initial_iteration_count;
  logic decremented;

  // ****************************************
  // Decode
  // ****************************************
  wire stack_empty = (depth == DEPTH_EMPTY);
  wire stack_full = (depth == DEPTH_FULL);
  wire [2:0] top = stack_empty ? 3'h0 : depth - 3'h1;
  wire [DATA_W-1:0] top_addr = addr_stack[top];
  wire [DATA_W-1:0] top_count = count_stack[top];
  wire [TYPE_W-1:0] top_kind = top_addr[TYPE_LSB +: TYPE_W];
  wire any_push = loop_start || push_loop;
  wire push_ovf = any_push && stack_full;
  wire push_ok = any_push && !stack_full;
  // Push wins over pop in the same cycle
  wire pop_ok = !any_push && (loop_terminate || pop_loop) && !stack_empty;
  wire [2:0] next_depth = push_ok ? depth + 3'h1 : (pop_ok ? depth - 3'h1 : depth);
  wire [DATA_W-1:0] start_entry = {loop_kind, 1'b0, loop_cond_code, loop_end_addr};
  wire wr_addr = reg_wr && (reg_sel == SEL_END_ADDR) && !stack_empty;
  wire running_counter = !stack_empty && is_counter(top_kind);
  wire wr_count = reg_wr && (reg_sel == SEL_CUR_COUNT) && running_counter;
  wire wr_init = reg_wr && (reg_sel == SEL_INIT_COUNT) && !stack_full;
  wire wr_sticky = reg_wr && (reg_sel == SEL_STICKY);
  wire stage_hit = (top_kind == LOOP_COUNT_FETCH) ? fetch_stage_terminated_loop
                                                  : execute_stage_terminated_loop;
  wire dec_req = running_counter && stage_hit && !decremented && !wr_count;
  // Zero count wraps to all ones for a full 2^32 run
  wire [DATA_W-1:0] dec_count = top_count - COUNT_STEP;
  wire next_ovf = push_ovf || (wr_sticky ? reg_wdata[OVF_BIT] : loop_stacks_overflowed_flag);
  wire next_decremented = (loop_top_fetch || any_push || pop_ok) ? 1'b0 : (decremented || dec_req);
  wire next_expired = !(next_depth == DEPTH_EMPTY);

  // Read mux; empty stacks read all ones
  wire [DATA_W-1:0] sticky_word = (WORD_ZERO | ({31'h0, loop_stacks_overflowed_flag} << OVF_BIT))
                                  | ({31'h0, stack_empty} << EMPTY_BIT);
  wire [DATA_W-1:0] end_addr_word = stack_empty ? EMPTY_READ : top_addr;
  wire [DATA_W-1:0] cur_count_word = stack_empty ? EMPTY_READ : top_count;
  wire [DATA_W-1:0] init_word = stack_full ? FULL_INIT_READ : initial_iteration_count;
  wire [DATA_W-1:0] next_rdata = (reg_sel == SEL_STICKY) ? sticky_word :
                                 (reg_sel == SEL_END_ADDR) ? end_addr_word :
                                 (reg_sel == SEL_CUR_COUNT) ? cur_count_word : init_word;

  // ****************************************
  // Pointer and flags
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth <= DEPTH_EMPTY;
      decremented <= 1'b0;
      loop_stacks_overflowed_flag <= 1'b0;
      loop_stacks_empty_flag <= 1'b1;
      overflow_irq <= 1'b0;
    end else begin
      depth <= next_depth;
      decremented <= next_decremented;
      loop_stacks_overflowed_flag <= next_ovf;
      loop_stacks_empty_flag <= (next_depth == DEPTH_EMPTY);
      overflow_irq <= push_ovf && !irq_mask;
    end
  end

  // Pointer moves by one per push or pop
  a_push_depth: assert property (@(posedge clk) disable iff (!rst_n)
    push_ok |=> (depth == $past(depth) + 3'h1))
    else $error("push did not advance pointer");

  a_pop_depth: assert property (@(posedge clk) disable iff (!rst_n)
    pop_ok |=> (depth == $past(depth) - 3'h1))
    else $error("pop did not retreat pointer");

  a_pop_empty: assert property (@(posedge clk) disable iff (!rst_n)
    (!any_push && stack_empty) |=> stack_empty)
    else $error("pop on empty stack moved pointer");

  a_last_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (pop_ok && (depth == 3'h1)) |=> loop_stacks_empty_flag)
    else $error("empty flag missing after last pop");

  a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
    irq_mask |=> !overflow_irq)
    else $error("masked overflow raised interrupt");

  a_irq_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    overflow_irq |-> $past(push_ovf))
    else $error("interrupt without overflowing push");

  // ****************************************
  // Stack entries
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        addr_stack[i] <= EMPTY_READ;
        count_stack[i] <= EMPTY_READ;
      end
    end else begin
      if (loop_start && push_ok) begin
        addr_stack[depth] <= start_entry;
        count_stack[depth] <= initial_iteration_count;
      end else if (wr_addr) begin
        addr_stack[top] <= reg_wdata;
      end
      if (!(loop_start && push_ok)) begin
        if (wr_count) begin
          count_stack[top] <= reg_wdata;
        end else if (dec_req) begin
          count_stack[top] <= dec_count;
        end
      end
    end
  end

  // Entries written by a loop start and kept by an explicit push
  a_start_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (loop_start && push_ok) |=> ((top_addr[ADDR_LSB +: ADDR_W] == $past(loop_end_addr))
    && (top_addr[COND_LSB +: COND_W] == $past(loop_cond_code))
    && (top_kind == $past(loop_kind))))
    else $error("loop start entry wrong");

  a_start_count: assert property (@(posedge clk) disable iff (!rst_n)
    (loop_start && push_ok) |=> (top_count == $past(initial_iteration_count)))
    else $error("loop start count wrong");

  a_push_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (push_loop && !loop_start && push_ok) |=> (top_addr == $past(addr_stack[depth])))
    else $error("explicit push altered entry");

  a_count_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && (reg_sel == SEL_CUR_COUNT) && stack_empty && !any_push)
    |=> $stable(count_stack[0]))
    else $error("count write landed on empty stack");

  a_count_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    (dec_req && (top_count == WORD_ZERO) && !(loop_start && push_ok))
    |=> (count_stack[$past(top)] == {DATA_W{1'b1}}))
    else $error("zero count did not wrap");

  a_addr_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_addr && !(loop_start && push_ok)) |=> (addr_stack[$past(top)] == $past(reg_wdata)))
    else $error("end address write lost");

  // ****************************************
  // Core registers and outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      initial_iteration_count <= WORD_ZERO;
      reg_rdata <= WORD_ZERO;
      count_expired_condition <= 1'b0;
      mult_status_abort <= 1'b0;
    end else begin
      if (wr_init) begin
        initial_iteration_count <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
      count_expired_condition <= running_counter && (top_count == COUNT_LAST) && next_expired;
      mult_status_abort <= mult_status;
    end
  end

  // Register reads and the initial-count guard
  a_init_discard: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && (reg_sel == SEL_INIT_COUNT) && stack_full)
    |=> $stable(initial_iteration_count))
    else $error("initial count written while full");

  a_sticky_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_sel == SEL_STICKY)) |=> (reg_rdata[EMPTY_BIT] == $past(stack_empty)))
    else $error("empty bit read wrong");

  a_count_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_sel == SEL_CUR_COUNT) && !stack_empty)
    |=> (reg_rdata == $past(top_count)))
    else $error("current count read wrong");

  // ****************************************
  // Checks
  // ****************************************
  a_overflow_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (any_push && stack_full) |=> loop_stacks_overflowed_flag)
    else $error("overflow flag not set on full push");

  a_overflow_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (loop_stacks_overflowed_flag && !wr_sticky) |=> loop_stacks_overflowed_flag)
    else $error("overflow flag cleared without software write");

  a_irq_on_overflow: assert property (@(posedge clk) disable iff (!rst_n)
    (push_ovf && !irq_mask) |=> overflow_irq)
    else $error("overflow interrupt missing");

  a_depth_bound: assert property (@(posedge clk) disable iff (!rst_n)
    depth <= DEPTH_FULL)
    else $error("stack depth beyond six");

  a_full_push_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_full && any_push) |=> stack_full)
    else $error("depth moved on overflowing push");

  a_access_no_move: assert property (@(posedge clk) disable iff (!rst_n)
    (!any_push && !loop_terminate && !pop_loop) |=> $stable(depth))
    else $error("register access moved pointer");

  a_empty_flag: assert property (@(posedge clk) disable iff (!rst_n)
    push_ok |=> !loop_stacks_empty_flag)
    else $error("empty flag still set after push");

  a_empty_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && stack_empty && reg_sel != SEL_STICKY && reg_sel != SEL_INIT_COUNT)
    |=> (reg_rdata == EMPTY_READ))
    else $error("empty stack read not all ones");

  a_mult_latency: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mult_status) |=> mult_status_abort)
    else $error("abort status latency wrong");

  a_count_write: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_count && !(loop_start && push_ok)) |=> (count_stack[$past(top)] == $past(reg_wdata)))
    else $error("current count write lost");

  a_single_dec: assert property (@(posedge clk) disable iff (!rst_n)
    (dec_req && !loop_top_fetch && !any_push && !pop_ok) |=> !dec_req)
    else $error("count decremented twice in one iteration");

endmodule : hardware_loop_stack_unit

// file: src/loop_stack_pkg.sv
// Constants and types of the loop-stack unit
package loop_stack_pkg;

  // ****************************************
  // Stack geometry
  // ****************************************
  localparam int unsigned STACK_DEPTH = 6;
  localparam int unsigned DATA_W = 32;
  localparam logic [2:0] DEPTH_FULL = 3'h6;
  localparam logic [2:0] DEPTH_EMPTY = 3'h0;
  localparam logic [31:0] EMPTY_READ = 32'hFFFFFFFF;
  localparam logic [31:0] FULL_INIT_READ = 32'h00000000;
  localparam logic [31:0] COUNT_LAST = 32'h00000001;
  localparam logic [31:0] COUNT_STEP = 32'h00000001;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // ****************************************
  // Core register select codes
  // ****************************************
  localparam logic [1:0] SEL_STICKY = 2'h0;
  localparam logic [1:0] SEL_END_ADDR = 2'h1;
  localparam logic [1:0] SEL_CUR_COUNT = 2'h2;
  localparam logic [1:0] SEL_INIT_COUNT = 2'h3;

  // ****************************************
  // Sticky status fields
  // ****************************************
  localparam int unsigned OVF_BIT = 25;
  localparam int unsigned EMPTY_BIT = 26;

  // ****************************************
  // End-address entry layout
  // ****************************************
  localparam int unsigned ADDR_LSB = 0;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned COND_LSB = 24;
  localparam int unsigned COND_W = 5;
  localparam int unsigned TYPE_LSB = 30;
  localparam int unsigned TYPE_W = 2;

  typedef enum logic [1:0] {
    LOOP_COUNT_EXEC = 2'h0,
    LOOP_COUNT_FETCH = 2'h1,
    LOOP_ARITH = 2'h2,
    LOOP_FOREVER = 2'h3
  } loop_type_t;

endpackage : loop_stack_pkg

// file: testbench/seq_model.sv
// Sequencer-side model that turns bench commands into loop control pulses
`timescale 1ns/1ps
module seq_model (
  // Command from bench
  input wire logic [2:0] op,
  // Loop control pulses
  output logic loop_start,
  output logic loop_terminate,
  output logic push_loop,
  output logic pop_loop,
  output logic loop_top_fetch,
  output logic fetch_stage_terminated_loop,
  output logic execute_stage_terminated_loop
);
  // ****
  // One pulse per nonzero command; op 0 is idle and drives no pulse
  // ****
  assign loop_start = (op == 3'h1);
  assign loop_terminate = (op == 3'h2);
  assign push_loop = (op == 3'h3);
  assign pop_loop = (op == 3'h4);
  assign loop_top_fetch = (op == 3'h5);
  assign fetch_stage_terminated_loop = (op == 3'h6);
  assign execute_stage_terminated_loop = (op == 3'h7);
endmodule : seq_model

// file: testbench/tb.sv
// Self-checking bench for the loop-stack unit
`timescale 1ns/1ps
module tb;
  import loop_stack_pkg::*;
  logic clk, rst_n, ls, lt, pu, po, tf, fs, es, ms, ma, rd_s, wr_s, msk, irq, exp_c, emp, ovf;
  logic [2:0] op;
  logic [1:0] sel, kind;
  logic [4:0] cond;
  logic [23:0] addr;
  logic [31:0] wd, rdat, rnd, got, ms_last, mrnd;
  logic [31:0] ent [6];
  logic [31:0] cnt [6];
  int mismatches, cmp_count;
  bit live;
  seq_model i_seq (.op(op), .loop_start(ls), .loop_terminate(lt), .push_loop(pu),
    .pop_loop(po), .loop_top_fetch(tf), .fetch_stage_terminated_loop(fs),
    .execute_stage_terminated_loop(es));
  hardware_loop_stack_unit i_dut (.clk(clk), .rst_n(rst_n), .loop_start(ls),
    .loop_end_addr(addr), .loop_cond_code(cond), .loop_kind(kind), .loop_terminate(lt),
    .push_loop(pu), .pop_loop(po), .loop_top_fetch(tf), .fetch_stage_terminated_loop(fs),
    .execute_stage_terminated_loop(es), .mult_status(ms), .mult_status_abort(ma),
    .reg_rd(rd_s), .reg_wr(wr_s), .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rdat),
    .irq_mask(msk), .overflow_irq(irq), .count_expired_condition(exp_c),
    .loop_stacks_empty_flag(emp), .loop_stacks_overflowed_flag(ovf));
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic stop_test;
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic cyc(input logic [2:0] c);
    @(posedge clk); #1 op = c;
    @(posedge clk); #1 op = 3'h0;
  endtask : cyc
  task automatic rd(input logic [1:0] s);
    @(posedge clk); #1 sel = s; rd_s = 1'b1;
    @(posedge clk); #1 rd_s = 1'b0; got = rdat;
  endtask : rd
  task automatic wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk); #1 sel = s; wd = d; wr_s = 1'b1;
    @(posedge clk); #1 wr_s = 1'b0;
  endtask : wr
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction : b
  // ****
  // Clock, watchdog and abort-path monitor
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 3000);
    mismatches++;
    stop_test();
  end
  initial begin
    ms = 1'b0;
    ms_last = '0;
    live = 1'b0;
    mrnd = 32'h52;
    forever begin
      @(posedge clk); #1;
      if (live) check(b(ma), ms_last);
      live = rst_n;
      mrnd = lfsr(mrnd);
      ms = mrnd[5];
      ms_last = b(mrnd[5]);
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    {op, rd_s, wr_s, sel, msk, kind, cond, addr} = '0;
    wd = '0; rnd = 32'h52; rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    rd(SEL_END_ADDR); check(got, EMPTY_READ);
    wr(SEL_CUR_COUNT, 32'h5); rd(SEL_CUR_COUNT); check(got, EMPTY_READ);
    rd(SEL_STICKY); check(got, 32'h04000000);
    for (int i = 0; i < 7; i++) begin
      rnd = lfsr(rnd);
      {kind, cond, addr} = {rnd[31:30], rnd[28:0]};
      wr(SEL_INIT_COUNT, rnd ^ 32'h0F0F0F0F);
      cyc(3'h1);
      if (i < 6) begin
        ent[i] = {rnd[31:30], 1'b0, rnd[28:0]};
        cnt[i] = rnd ^ 32'h0F0F0F0F;
        check(b(emp), 32'h0);
        rd(SEL_END_ADDR); check(got, ent[i]);
        rd(SEL_CUR_COUNT); check(got, cnt[i]);
      end else begin
        check(b(irq), 32'h1);
        check(b(ovf), 32'h1);
        rd(SEL_END_ADDR); check(got, ent[5]);
        rd(SEL_INIT_COUNT); check(got, FULL_INIT_READ);
      end
    end
    msk = 1'b1;
    cyc(3'h1); check(b(irq), 32'h0);
    for (int i = 5; i > 0; i--) begin
      cyc(3'h2);
      rd(SEL_END_ADDR); check(got, ent[i-1]);
      rd(SEL_CUR_COUNT); check(got, cnt[i-1]);
      if (i == 5) begin
        rd(SEL_INIT_COUNT);
        check(got, cnt[5]);
      end
    end
    check(b(ovf), 32'h1);
    cyc(3'h4); check(b(emp), 32'h1);
    cyc(3'h3); check(b(emp), 32'h0);
    rd(SEL_END_ADDR); check(got, ent[0]);
    wr(SEL_END_ADDR, rnd); rd(SEL_END_ADDR); check(got, rnd);
    check(b(emp), 32'h0);
    cyc(3'h4);
    wr(SEL_STICKY, 32'h0); rd(SEL_STICKY); check(got, 32'h04000000);
    kind = LOOP_COUNT_EXEC;
    wr(SEL_INIT_COUNT, 32'h0); cyc(3'h1); cyc(3'h7);
    rd(SEL_CUR_COUNT); check(got, EMPTY_READ);
    cyc(3'h5); wr(SEL_CUR_COUNT, 32'h2);
    rd(SEL_CUR_COUNT); check(got, 32'h2);
    cyc(3'h6); rd(SEL_CUR_COUNT); check(got, 32'h2);
    cyc(3'h7); rd(SEL_CUR_COUNT); check(got, 32'h1);
    check(b(exp_c), 32'h1);
    cyc(3'h7); rd(SEL_CUR_COUNT); check(got, 32'h1);
    cyc(3'h2); check(b(emp), 32'h1);
    kind = LOOP_COUNT_FETCH;
    wr(SEL_INIT_COUNT, 32'h3);
    cyc(3'h1);
    cyc(3'h7);
    cyc(3'h6);
    rd(SEL_CUR_COUNT); check(got, 32'h2);
    kind = LOOP_ARITH;
    wr(SEL_INIT_COUNT, 32'h9);
    cyc(3'h1);
    wr(SEL_CUR_COUNT, 32'h5);
    cyc(3'h6);
    rd(SEL_CUR_COUNT); check(got, 32'h9);
    cyc(3'h2);
    rd(SEL_CUR_COUNT); check(got, 32'h2);
    stop_test();
  end
endmodule : tb
